// ### flss_clk_div.sv
/*
 Divider that turns a loop clock-enable into a slower GPIO clock.
 Assumes i_tick is a one-cycle pulse per loop output edge.
*/
`timescale 1ns/1ps
`default_nettype none

module flss_clk_div (
  input wire logic i_clk,        // Register clock
  input wire logic i_rst_b,      // Sync reset, low
  input wire logic i_run,        // Loop delivering clock
  input wire logic i_tick,       // Loop output enable pulse
  input wire logic [3:0] i_half, // Half period in ticks minus one
  output logic o_clk_out         // Derived clock level
);
  logic [3:0] cnt_r;
  logic out_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_run) begin
      cnt_r <= 4'h0;
      out_r <= 1'b0;
    end else if (i_tick) begin
      if (cnt_r >= i_half) begin
        cnt_r <= 4'h0;
        out_r <= ~out_r;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  assign o_clk_out = out_r;

endmodule // flss_clk_div

`default_nettype wire

// ### flss_params.svh
/*
 Constants for the loop spread-spectrum and status block: register
 offsets, field positions, reset values and the timing counts.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef FLSS_PARAMS_SVH
`define FLSS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------
`define FLSS_ADDR_W 12
`define FLSS_OFS_LOOP1_SPREAD 12'h189
`define FLSS_OFS_LOOP2_SPREAD 12'h1a9
`define FLSS_OFS_INT_STATUS 12'h1c0
`define FLSS_OFS_INT_CLEAR 12'h1c1
`define FLSS_OFS_INT_ENABLE 12'h1c2
`define FLSS_OFS_LOOP_STATUS 12'h1c3
`define FLSS_OFS_GPIO_SEL 12'h1c4
`define FLSS_OFS_LOOP1_INT_MULT 12'h1c8
`define FLSS_OFS_LOOP1_NUMER 12'h1c9
`define FLSS_OFS_LOOP1_DENOM 12'h1ca
`define FLSS_OFS_LOOP2_INT_MULT 12'h1cc
`define FLSS_OFS_LOOP2_NUMER 12'h1cd
`define FLSS_OFS_LOOP2_DENOM 12'h1ce

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLSS_TYPE_LSB 0
`define FLSS_RATE_LSB 2
`define FLSS_DEPTH_LSB 4
`define FLSS_SPREAD_USED_W 6
`define FLSS_INT_MULT_W 10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLSS_SPREAD_RST 16'h0000
`define FLSS_INT_EN_RST 4'h0
`define FLSS_GPIO_SEL_RST 16'h0000
`define FLSS_DENOM_RST 16'h0001

// ----------------------------------------------------------------
// Timing: sync depth in cycles of i_clk
// ----------------------------------------------------------------
`define FLSS_SYNC_STAGES 2

`endif

// ### flss_pkg.sv
/*
 Types for the loop spread-spectrum and status block.
 Assumes flss_params.svh is on the include path.
*/
`include "flss_params.svh"

package flss_pkg;

  typedef enum logic [1:0] {
    FLSS_MOD_OFF = 2'b00,
    FLSS_MOD_TRIANGLE = 2'b01,
    FLSS_MOD_ZERO_MEAN = 2'b10,
    FLSS_MOD_DITHER = 2'b11
  } flss_mod_t;

  // One loop's modulation settings as presented to the loop core
  typedef struct packed {
    flss_mod_t spread_type;
    logic [1:0] spread_rate;
    logic [1:0] spread_depth;
  } flss_spread_t;

  // One loop's ratio terms as presented to the loop core
  typedef struct packed {
    logic [`FLSS_INT_MULT_W-1:0] integer_mult;
    logic [15:0] frac_numerator;
    logic [15:0] frac_denominator;
  } flss_ratio_t;

  // Raw status from one loop core
  typedef struct packed {
    logic clock_ok;
    logic locked;
  } flss_status_t;

  typedef enum logic [1:0] {
    FLSS_BUS_IDLE = 2'b00,
    FLSS_BUS_READ = 2'b01,
    FLSS_BUS_WRITE = 2'b10
  } flss_bus_op_t;

endpackage : flss_pkg

// ### flss_sync.sv
/*
 Two-flop level synchroniser for one loop's status pair.
 Assumes the status inputs are levels from the loop core domain.
*/
`timescale 1ns/1ps
`default_nettype none

module flss_sync (
  input wire logic i_clk,                     // Register clock
  input wire logic i_rst_b,                   // Sync reset, low
  input wire flss_pkg::flss_status_t i_raw,   // Asynchronous status
  output flss_pkg::flss_status_t o_sync       // Synchronised status
);
  import flss_pkg::*;

  flss_status_t meta_r;
  flss_status_t sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_raw;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule // flss_sync

`default_nettype wire

// ### flss_top.sv
/*
 Register, status and GPIO-select logic for two frequency-locked loops.
 Assumes a single 200 MHz clock and a plain one-cycle register port.
*/
// Added by the designer: strobed register access.
// Overview of operation
// R01: Each loop has its own spread-spectrum control register.
// R02: Bits 1:0 pick off, triangle, zero-mean modulation or dither.
// R03: Bits 5:4 set modulation depth, meaning depends on mode.
// R04: Bits 3:2 set triangle rate, 439 kHz to 1.76 MHz.
// R05: Clock-OK shows each loop started and delivering clock.
// R06: Lock status shows each loop currently holds frequency lock.
// R07: Clock-OK and lock of each loop are interrupt events.
// R08: Clock-OK and lock of each loop selectable onto GPIO.
// R09: A clock derived from each loop selectable onto GPIO.
// R10: Software loads integer multiplier with integer part of ratio.
// R11: Software computes numerator and denominator over common divisor.
// R12: Integer, numerator, denominator fields drive each loop's terms.
// R13: Software keeps divided reference at or below 13.5 MHz.
// R14: Status is synchronised into the register clock domain first.
`timescale 1ns/1ps
`default_nettype none
`include "flss_params.svh"

module flss_top (
  input wire logic i_clk,                          // 200 MHz clock
  input wire logic i_rst_b,                        // Sync reset, low
  input wire logic [`FLSS_ADDR_W-1:0] i_addr,      // Register address
  input wire logic [15:0] i_wdata,                 // Write data
  input wire logic i_wr,                           // Write strobe
  input wire logic i_rd,                           // Read strobe
  output logic [15:0] o_rdata,                     // Read data, next cycle
  input wire flss_pkg::flss_status_t i_loop1_raw,  // Loop 1 core status
  input wire flss_pkg::flss_status_t i_loop2_raw,  // Loop 2 core status
  input wire logic i_loop1_tick,                   // Loop 1 output pulse
  input wire logic i_loop2_tick,                   // Loop 2 output pulse
  output flss_pkg::flss_spread_t o_loop1_spread,   // Loop 1 modulation
  output flss_pkg::flss_spread_t o_loop2_spread,   // Loop 2 modulation
  output flss_pkg::flss_ratio_t o_loop1_ratio,     // Loop 1 ratio terms
  output flss_pkg::flss_ratio_t o_loop2_ratio,     // Loop 2 ratio terms
  output logic [1:0] o_gpio,                       // Two GPIO functions
  output logic o_irq                               // Level interrupt
);
  import flss_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] spread_r [2];
  logic [`FLSS_INT_MULT_W-1:0] mult_r [2];
  logic [15:0] numer_r [2];
  logic [15:0] denom_r [2];
  logic [3:0] int_stat_r;
  logic [3:0] int_en_r;
  logic [15:0] gpio_sel_r;
  logic [15:0] rdata_r;
  flss_status_t st_sync [2];
  flss_status_t st_prev_r [2];
  logic [3:0] evt;
  logic [3:0] clr;
  logic [1:0] clk_div_out;
  logic [1:0] tick;
  flss_bus_op_t op;

  // Loop index for a per-loop register, or 2'd2 when not per-loop
  function automatic logic [1:0] loop_of(
    input logic [`FLSS_ADDR_W-1:0] a,
    input logic [`FLSS_ADDR_W-1:0] ofs1,
    input logic [`FLSS_ADDR_W-1:0] ofs2
  );
    loop_of = (a == ofs1) ? 2'd0 : (a == ofs2) ? 2'd1 : 2'd2;
  endfunction

  always_comb begin
    op = FLSS_BUS_IDLE;
    if (i_wr) begin
      op = FLSS_BUS_WRITE;
    end else if (i_rd) begin
      op = FLSS_BUS_READ;
    end
  end

  // ----------------------------------------------------------------
  // Status synchronisers and event detection
  // ----------------------------------------------------------------
  flss_sync u_sync1 (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_raw(i_loop1_raw),
    .o_sync(st_sync[0])
  ); // see R14
  flss_sync u_sync2 (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_raw(i_loop2_raw),
    .o_sync(st_sync[1])
  ); // see R14

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_prev_r[0] <= '0;
      st_prev_r[1] <= '0;
    end else begin
      st_prev_r[0] <= st_sync[0];
      st_prev_r[1] <= st_sync[1];
    end
  end

  // Any change of either status is an event; both edges matter
  always_comb begin
    evt[0] = st_sync[0].clock_ok ^ st_prev_r[0].clock_ok; // see R05, R07
    evt[1] = st_sync[0].locked ^ st_prev_r[0].locked;     // see R06, R07
    evt[2] = st_sync[1].clock_ok ^ st_prev_r[1].clock_ok; // see R05, R07
    evt[3] = st_sync[1].locked ^ st_prev_r[1].locked;     // see R06, R07
  end

  assign clr = (op == FLSS_BUS_WRITE && i_addr == `FLSS_OFS_INT_CLEAR)
             ? i_wdata[3:0] : 4'h0;

  // ----------------------------------------------------------------
  // Interrupt status, enable and output
  // ----------------------------------------------------------------
  // Set wins over clear so an event in the clear cycle survives
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      int_stat_r <= 4'h0;
    end else begin
      int_stat_r <= (int_stat_r & ~clr) | evt; // see R07
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      int_en_r <= `FLSS_INT_EN_RST;
    end else if (op == FLSS_BUS_WRITE && i_addr == `FLSS_OFS_INT_ENABLE) begin
      int_en_r <= i_wdata[3:0];
    end
  end

  assign o_irq = |(int_stat_r & int_en_r); // see R07

  // ----------------------------------------------------------------
  // Per-loop configuration registers
  // ----------------------------------------------------------------
  // Spread registers implement only bits 5:0; upper bits read as zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 2; i++) begin
        spread_r[i] <= `FLSS_SPREAD_RST;
        mult_r[i] <= '0;
        numer_r[i] <= 16'h0000;
        denom_r[i] <= `FLSS_DENOM_RST;
      end
    end else if (op == FLSS_BUS_WRITE) begin
      for (int i = 0; i < 2; i++) begin
        if (loop_of(i_addr, `FLSS_OFS_LOOP1_SPREAD,
                    `FLSS_OFS_LOOP2_SPREAD) == 2'(i)) begin
          spread_r[i] <= {10'h000,
                          i_wdata[`FLSS_SPREAD_USED_W-1:0]}; // see R01
        end
        if (loop_of(i_addr, `FLSS_OFS_LOOP1_INT_MULT,
                    `FLSS_OFS_LOOP2_INT_MULT) == 2'(i)) begin
          mult_r[i] <= i_wdata[`FLSS_INT_MULT_W-1:0]; // see R12
        end
        if (loop_of(i_addr, `FLSS_OFS_LOOP1_NUMER,
                    `FLSS_OFS_LOOP2_NUMER) == 2'(i)) begin
          numer_r[i] <= i_wdata; // see R12
        end
        if (loop_of(i_addr, `FLSS_OFS_LOOP1_DENOM,
                    `FLSS_OFS_LOOP2_DENOM) == 2'(i)) begin
          denom_r[i] <= i_wdata; // see R12
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gpio_sel_r <= `FLSS_GPIO_SEL_RST;
    end else if (op == FLSS_BUS_WRITE && i_addr == `FLSS_OFS_GPIO_SEL) begin
      gpio_sel_r <= i_wdata;
    end
  end

  // Fields go to the core as-is; the core maps codes to percent and rate
  always_comb begin
    o_loop1_spread.spread_type =
      flss_mod_t'(spread_r[0][`FLSS_TYPE_LSB +: 2]);      // see R02
    o_loop1_spread.spread_rate = spread_r[0][`FLSS_RATE_LSB +: 2];   // see R04
    o_loop1_spread.spread_depth = spread_r[0][`FLSS_DEPTH_LSB +: 2]; // see R03
    o_loop2_spread.spread_type =
      flss_mod_t'(spread_r[1][`FLSS_TYPE_LSB +: 2]);      // see R02
    o_loop2_spread.spread_rate = spread_r[1][`FLSS_RATE_LSB +: 2];   // see R04
    o_loop2_spread.spread_depth = spread_r[1][`FLSS_DEPTH_LSB +: 2]; // see R03
  end

  // Zero denominator is passed through; software must avoid it
  always_comb begin
    o_loop1_ratio = {mult_r[0], numer_r[0], denom_r[0]}; // see R12
    o_loop2_ratio = {mult_r[1], numer_r[1], denom_r[1]}; // see R12
  end

  // ----------------------------------------------------------------
  // GPIO selection: 3-bit code per output
  // ----------------------------------------------------------------
  assign tick = {i_loop2_tick, i_loop1_tick};

  for (genvar g = 0; g < 2; g++) begin : g_div
    flss_clk_div u_div (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_run(st_sync[g].clock_ok),
      .i_tick(tick[g]),
      .i_half(gpio_sel_r[8 + 4*g +: 4]),
      .o_clk_out(clk_div_out[g])
    ); // see R09
  end

  function automatic logic gpio_pick(input logic [2:0] code,
                                     input flss_status_t s1,
                                     input flss_status_t s2,
                                     input logic [1:0] ck);
    case (code)
      3'h1: gpio_pick = s1.clock_ok;
      3'h2: gpio_pick = s1.locked;
      3'h3: gpio_pick = s2.clock_ok;
      3'h4: gpio_pick = s2.locked;
      3'h5: gpio_pick = ck[0];
      3'h6: gpio_pick = ck[1];
      default: gpio_pick = 1'b0;
    endcase
  endfunction

  logic [1:0] gpio_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gpio_r <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        gpio_r[k] <= gpio_pick(gpio_sel_r[4*k +: 3], st_sync[0],
                               st_sync[1], clk_div_out); // see R08, R09
      end
    end
  end
  assign o_gpio = gpio_r;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_r <= 16'h0000;
    end else if (op == FLSS_BUS_READ) begin
      case (i_addr)
        `FLSS_OFS_LOOP1_SPREAD: rdata_r <= spread_r[0];
        `FLSS_OFS_LOOP2_SPREAD: rdata_r <= spread_r[1];
        `FLSS_OFS_INT_STATUS: rdata_r <= {12'h000, int_stat_r};
        `FLSS_OFS_INT_ENABLE: rdata_r <= {12'h000, int_en_r};
        `FLSS_OFS_LOOP_STATUS: rdata_r <= {12'h000, st_sync[1], st_sync[0]};
        `FLSS_OFS_GPIO_SEL: rdata_r <= gpio_sel_r;
        `FLSS_OFS_LOOP1_INT_MULT: rdata_r <= {6'h00, mult_r[0]};
        `FLSS_OFS_LOOP1_NUMER: rdata_r <= numer_r[0];
        `FLSS_OFS_LOOP1_DENOM: rdata_r <= denom_r[0];
        `FLSS_OFS_LOOP2_INT_MULT: rdata_r <= {6'h00, mult_r[1]};
        `FLSS_OFS_LOOP2_NUMER: rdata_r <= numer_r[1];
        `FLSS_OFS_LOOP2_DENOM: rdata_r <= denom_r[1];
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign o_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_spread_write: assert property ( // see R01
    i_wr && i_addr == `FLSS_OFS_LOOP1_SPREAD |=>
      spread_r[0][5:0] == $past(i_wdata[5:0]) && spread_r[0][15:6] == 10'h0)
    else $error("loop 1 spread write not stored");
  a_type_field: assert property ( // see R02
    i_wr && i_addr == `FLSS_OFS_LOOP2_SPREAD |=>
      o_loop2_spread.spread_type == flss_mod_t'($past(i_wdata[1:0])))
    else $error("loop 2 type field wrong");
  a_depth_field: assert property ( // see R03
    i_wr && i_addr == `FLSS_OFS_LOOP1_SPREAD |=>
      o_loop1_spread.spread_depth == $past(i_wdata[5:4]))
    else $error("loop 1 depth field wrong");
  a_rate_field: assert property ( // see R04
    i_wr && i_addr == `FLSS_OFS_LOOP1_SPREAD |=>
      o_loop1_spread.spread_rate == $past(i_wdata[3:2]))
    else $error("loop 1 rate field wrong");
  a_lock_event: assert property ( // see R06
    $rose(st_sync[0].locked) |=> int_stat_r[1])
    else $error("lock rise did not set status");
  a_clkok_sync: assert property ( // see R14
    i_loop1_raw.clock_ok && $past(i_loop1_raw.clock_ok) &&
    $past(i_loop1_raw.clock_ok, 2) && $past(i_rst_b) &&
    $past(i_rst_b, 2) |-> st_sync[0].clock_ok)
    else $error("clock ok not synchronised in two cycles");
  a_irq_level: assert property ( // see R07
    |(evt & int_en_r) && !(i_wr && i_addr == `FLSS_OFS_INT_ENABLE) |=>
      o_irq)
    else $error("interrupt not raised");
  a_event_sets: assert property ( // see R07
    evt[2] |=> int_stat_r[2])
    else $error("loop 2 clock ok event not latched");
  a_clear_bit: assert property ( // see R07
    clr[0] && !evt[0] |=> !int_stat_r[0])
    else $error("status bit 0 not cleared");
  a_status_read: assert property ( // see R05
    i_rd && !i_wr && i_addr == `FLSS_OFS_LOOP_STATUS |=>
      o_rdata == {12'h000, $past(st_sync[1]), $past(st_sync[0])})
    else $error("loop status read wrong");
  a_gpio_lock: assert property ( // see R08
    gpio_sel_r[2:0] == 3'h2 && $stable(gpio_sel_r) |=>
      o_gpio[0] == $past(st_sync[0].locked))
    else $error("gpio lock select wrong");
  a_ratio_write: assert property ( // see R12
    i_wr && i_addr == `FLSS_OFS_LOOP2_NUMER |=>
      o_loop2_ratio.frac_numerator == $past(i_wdata))
    else $error("loop 2 numerator not applied");
  a_read_clear: assert property ( // see R05
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data held past its cycle");

  c_triangle: cover property (o_loop1_spread.spread_type == FLSS_MOD_TRIANGLE);
  c_irq: cover property ($rose(o_irq));
  c_dither: cover property (o_loop2_spread.spread_type == FLSS_MOD_DITHER);
  c_clear_hit: cover property (|(clr & evt));
  c_gpio_clk: cover property (gpio_sel_r[2:0] == 3'h5 && $rose(o_gpio[0]));

endmodule // flss_top

`default_nettype wire

// ### testbench.sv
/*
 Self-checking bench for the loop spread-spectrum and status block.
 Assumes flss_pkg is compiled first and flss_params.svh is on the path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flss_params.svh"

module testbench;
  import flss_pkg::*;

  logic i_clk, i_rst_b, i_wr, i_rd, i_loop1_tick, i_loop2_tick;
  logic [`FLSS_ADDR_W-1:0] i_addr;
  logic [15:0] i_wdata, o_rdata, w;
  flss_status_t i_loop1_raw, i_loop2_raw;
  flss_spread_t o_loop1_spread, o_loop2_spread;
  flss_ratio_t o_loop1_ratio, o_loop2_ratio;
  logic [1:0] o_gpio, tick_cnt;
  logic o_irq;
  logic [3:0] st, v;
  logic [31:0] seed_r, r32;
  int mismatches, tests_run, i, c, g, n0, n1;

  flss_top dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_loop1_raw(i_loop1_raw), .i_loop2_raw(i_loop2_raw),
    .i_loop1_tick(i_loop1_tick), .i_loop2_tick(i_loop2_tick),
    .o_loop1_spread(o_loop1_spread), .o_loop2_spread(o_loop2_spread),
    .o_loop1_ratio(o_loop1_ratio), .o_loop2_ratio(o_loop2_ratio),
    .o_gpio(o_gpio), .o_irq(o_irq)
  );

  always #2.5 i_clk = ~i_clk;

  // Loop output pulses, one every four cycles, loops out of phase
  always @(posedge i_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    i_loop1_tick <= (tick_cnt == 2'h0);
    i_loop2_tick <= (tick_cnt == 2'h2);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed_r = seed_r ^ (seed_r << 13);
    seed_r = seed_r ^ (seed_r >> 17);
    seed_r = seed_r ^ (seed_r << 5);
    return seed_r;
  endfunction

  function automatic logic pick(input int idx);
    return (idx == 0) ? o_irq : o_gpio[idx-1];
  endfunction

  task automatic conclude;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk16(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_sp(input string n, input flss_spread_t e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_ra(input string n, input flss_ratio_t e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // Register port cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [15:0] e,
                       input string n);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk16(n, e, o_rdata);
  endtask

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] r);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    r = o_rdata;
  endtask

  task automatic set_raw(input logic [3:0] nv);
    @(posedge i_clk);
    st = nv;
    i_loop1_raw <= flss_status_t'({nv[0], nv[1]});
    i_loop2_raw <= flss_status_t'({nv[2], nv[3]});
    #1;
  endtask

  task automatic wait_sig(input string n, input int idx, input logic e);
    int k;
    for (k = 0; k < 10; k++) begin
      if (pick(idx) === e) break;
      @(posedge i_clk);
      #1;
    end
    chk1(n, e, pick(idx));
    if (pick(idx) !== e) conclude();
  endtask

  task automatic spread_case(input logic sel, input logic [15:0] d);
    flss_spread_t other, e;
    logic [15:0] r;
    other = sel ? o_loop1_spread : o_loop2_spread;
    e = flss_spread_t'({d[1:0], d[3:2], d[5:4]});
    wr_rd(sel ? `FLSS_OFS_LOOP2_SPREAD : `FLSS_OFS_LOOP1_SPREAD, d, r);
    chk16("spread readback", {10'h0, d[5:0]}, r);
    chk_sp("spread out", e, sel ? o_loop2_spread : o_loop1_spread);
    chk_sp("other loop", other, sel ? o_loop1_spread : o_loop2_spread);
  endtask

  task automatic ratio_case(input logic sel, input logic [15:0] n,
                            input logic [15:0] t, input logic [15:0] l);
    logic [11:0] b;
    flss_ratio_t got;
    b = sel ? `FLSS_OFS_LOOP2_INT_MULT : `FLSS_OFS_LOOP1_INT_MULT;
    wr(b, n);
    wr(b + 12'h001, t);
    wr(b + 12'h002, l);
    rdchk(b, {6'h0, n[9:0]}, "int mult readback");
    rdchk(b + 12'h001, t, "numerator readback");
    got = sel ? o_loop2_ratio : o_loop1_ratio;
    chk_ra("ratio out", {n[9:0], t, l}, got);
  endtask

  task automatic count_tog;
    logic [1:0] prev;
    prev = o_gpio;
    n0 = 0;
    n1 = 0;
    repeat (120) begin
      @(posedge i_clk);
      #1;
      if (o_gpio[0] !== prev[0]) n0++;
      if (o_gpio[1] !== prev[1]) n1++;
      prev = o_gpio;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 0; i_rst_b = 0; i_wr = 0; i_rd = 0; i_addr = '0; i_wdata = '0;
    i_loop1_tick = 0; i_loop2_tick = 0; tick_cnt = '0; st = '0;
    i_loop1_raw = '0; i_loop2_raw = '0; seed_r = 32'd3211;
    mismatches = 0; tests_run = 0;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk_sp("spread1 reset", '0, o_loop1_spread);
    chk_ra("ratio1 reset", {10'h0, 16'h0, 16'h1}, o_loop1_ratio);
    chk1("irq reset", 1'b0, o_irq);
    rdchk(`FLSS_OFS_LOOP1_SPREAD, 16'h0000, "spread1 rst");
    rdchk(`FLSS_OFS_LOOP2_SPREAD, 16'h0000, "spread2 rst");
    rdchk(`FLSS_OFS_LOOP2_DENOM, 16'h0001, "denom rst");
    rdchk(12'h000, 16'h0000, "unmapped");

    // Every mode, depth and rate code on both loops, then random words
    for (i = 0; i < 8; i++) begin
      w = {10'h0, i[1:0], 2'h3 - i[1:0], i[1:0]};
      spread_case(i[2], w);
    end
    for (i = 0; i < 8; i++) begin
      r32 = xs();
      spread_case(r32[16], r32[15:0]);
    end
    // Software terms for an undivided reference inside the input limit
    ratio_case(1'b0, 16'hfc08, 16'h0018, 16'h007d);
    r32 = xs();
    ratio_case(1'b1, r32[15:0], r32[31:16], r32[23:8]);

    // Each status rising edge is an event after the sync delay
    wr(`FLSS_OFS_INT_ENABLE, 16'h000f);
    rdchk(`FLSS_OFS_INT_ENABLE, 16'h000f, "int enable");
    for (i = 0; i < 4; i++) begin
      v = st | (4'h1 << i);
      set_raw(v);
      chk1("irq before sync", 1'b0, o_irq);
      wait_sig("irq raised", 0, 1'b1);
      rdchk(`FLSS_OFS_INT_STATUS, 16'h1 << i, "int status");
      w = {12'h0, v[2], v[3], v[0], v[1]};
      rdchk(`FLSS_OFS_LOOP_STATUS, w, "loop status");
      wr(`FLSS_OFS_INT_CLEAR, 16'h1 << i);
      wr(`FLSS_OFS_INT_STATUS, 16'hffff);
      rdchk(`FLSS_OFS_INT_STATUS, 16'h0000, "status cleared");
      chk1("irq cleared", 1'b0, o_irq);
    end
    // Masked lock loss stays pending until enabled
    wr(`FLSS_OFS_INT_ENABLE, 16'h0000);
    set_raw(st & 4'hd);
    repeat (8) @(posedge i_clk);
    #1;
    chk1("irq masked", 1'b0, o_irq);
    rdchk(`FLSS_OFS_INT_STATUS, 16'h0002, "masked status");
    wr(`FLSS_OFS_INT_ENABLE, 16'h0002);
    chk1("irq unmasked", 1'b1, o_irq);
    wr(`FLSS_OFS_INT_CLEAR, 16'h0002);
    wr(`FLSS_OFS_INT_ENABLE, 16'h0000);

    // Status functions on both GPIO outputs follow the loop
    for (c = 1; c < 5; c++) begin
      for (g = 0; g < 2; g++) begin
        wr(`FLSS_OFS_GPIO_SEL, g[0] ? (16'(c) << 4) : 16'(c));
        wait_sig("gpio status", g + 1, st[c-1]);
        set_raw(st ^ (4'h1 << (c - 1)));
        wait_sig("gpio follows", g + 1, st[c-1]);
      end
    end

    // Derived clocks run only while the loop reports clock OK
    set_raw(4'hf);
    wr(`FLSS_OFS_GPIO_SEL, 16'h3165);
    rdchk(`FLSS_OFS_GPIO_SEL, 16'h3165, "gpio select");
    count_tog();
    chk1("loop1 clk runs", 1'b1, n0 > 0);
    chk1("loop2 clk runs", 1'b1, n1 > 0);
    set_raw(4'h0);
    repeat (8) @(posedge i_clk);
    count_tog();
    chk1("loop1 clk stops", 1'b1, n0 == 0);
    chk1("loop2 clk stops", 1'b1, n1 == 0);
    conclude();
  end

  // Hang guard, well inside the cycle budget
  initial begin
    #200000;
    mismatches++;
    $display("MISMATCH watchdog expected done seen running");
    conclude();
  end

endmodule // testbench

`default_nettype wire
